// *** core/fpsc_lane.v ***
`timescale 1ns/10ps
`include "fpsc_regs.vh"

module fpsc_lane (
    mclk,
    rst,
    laneEnable,
    frameStart,
    scanDataPin,
    scanClear,
    scanClock,
    scanWord,
    scanValid
);
    input wire mclk;
    input wire rst;
    input wire laneEnable;
    input wire frameStart;
    input wire scanDataPin;
    output reg scanClear;
    output reg scanClock;
    output reg [`FPSC_POSITIONS-1:0] scanWord;
    output reg scanValid;

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_CLEAR = 3'h1;
    localparam [2:0] ST_HIGH = 3'h2;
    localparam [2:0] ST_LOW = 3'h3;

    localparam integer CLEAR_LAST_I = `FPSC_CLEAR_CYC - 1;
    localparam integer LOW_LAST_I = `FPSC_SCLK_LOW_CYC - 1;
    localparam integer HIGH_LAST_I = `FPSC_SCLK_CYC - `FPSC_SCLK_LOW_CYC - 1;
    localparam integer POS_LAST_I = `FPSC_POSITIONS - 1;
    localparam [`FPSC_TIMER_W-1:0] CLEAR_LAST =
        CLEAR_LAST_I[`FPSC_TIMER_W-1:0];
    localparam [`FPSC_TIMER_W-1:0] LOW_LAST = LOW_LAST_I[`FPSC_TIMER_W-1:0];
    localparam [`FPSC_TIMER_W-1:0] HIGH_LAST =
        HIGH_LAST_I[`FPSC_TIMER_W-1:0];
    localparam [`FPSC_POS_W-1:0] POS_LAST = POS_LAST_I[`FPSC_POS_W-1:0];

    reg [2:0] state_reg;
    reg [`FPSC_TIMER_W-1:0] timer_reg;
    reg [`FPSC_POS_W-1:0] pos_reg;
    reg dataMeta_reg;
    reg dataSync_reg;

    // ------------------------------------------------------------------
    // Data pin synchroniser
    // ------------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            dataMeta_reg <= 1'b0;
            dataSync_reg <= 1'b0;
        end else begin
            dataMeta_reg <= scanDataPin;
            dataSync_reg <= dataMeta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Clear pulse, clock pulses and sampling
    // ------------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            timer_reg <= {`FPSC_TIMER_W{1'b0}};
            pos_reg <= {`FPSC_POS_W{1'b0}};
            scanClear <= 1'b0;
            scanClock <= 1'b0;
            scanWord <= {`FPSC_POSITIONS{1'b0}};
            scanValid <= 1'b0;
        end else if (!laneEnable) begin
            // A lane switched off mid-scan stops at once and reports nothing
            state_reg <= ST_IDLE;
            scanClear <= 1'b0;
            scanClock <= 1'b0;
            scanValid <= 1'b0;
        end else begin
            scanValid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    // Disabled lane parks both lines low
                    scanClock <= laneEnable;
                    scanClear <= 1'b0;
                    if (frameStart && laneEnable) begin
                        scanClear <= 1'b1;
                        timer_reg <= CLEAR_LAST;
                        pos_reg <= {`FPSC_POS_W{1'b0}};
                        state_reg <= ST_CLEAR;
                    end
                end
                ST_CLEAR: begin
                    if (timer_reg == {`FPSC_TIMER_W{1'b0}}) begin
                        scanClear <= 1'b0;
                        timer_reg <= HIGH_LAST;
                        state_reg <= ST_HIGH;
                    end else begin
                        timer_reg <= timer_reg - 1'b1;
                    end
                end
                ST_HIGH: begin
                    if (timer_reg == {`FPSC_TIMER_W{1'b0}}) begin
                        // Value present now belongs to the current slot
                        scanWord[pos_reg] <= dataSync_reg;
                        scanClock <= 1'b0;
                        timer_reg <= LOW_LAST;
                        state_reg <= ST_LOW;
                    end else begin
                        timer_reg <= timer_reg - 1'b1;
                    end
                end
                ST_LOW: begin
                    if (timer_reg == {`FPSC_TIMER_W{1'b0}}) begin
                        scanClock <= 1'b1;
                        timer_reg <= HIGH_LAST;
                        if (pos_reg == POS_LAST) begin
                            scanValid <= 1'b1;
                            state_reg <= ST_IDLE;
                        end else begin
                            pos_reg <= pos_reg + 1'b1;
                            state_reg <= ST_HIGH;
                        end
                    end else begin
                        timer_reg <= timer_reg - 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // fpsc_lane

// *** core/fpsc_regs.vh ***
`ifndef FPSC_REGS_VH
`define FPSC_REGS_VH

// ----------------------------------------------------------------------
// Clock and panel timing
// ----------------------------------------------------------------------
`define FPSC_CLK_HZ 50000000
`define FPSC_CLK_NS 20
`define FPSC_FRAME_HZ 6440
`define FPSC_SCLK_HZ 405000
`define FPSC_CLEAR_NS 50
`define FPSC_SCLK_LOW_NS 50
`define FPSC_LATCH_NS 120

// Repetition periods round down, pulse widths round up
`define FPSC_FRAME_CYC (`FPSC_CLK_HZ / `FPSC_FRAME_HZ)
`define FPSC_SCLK_CYC (`FPSC_CLK_HZ / `FPSC_SCLK_HZ)
`define FPSC_CLEAR_CYC ((`FPSC_CLEAR_NS + `FPSC_CLK_NS - 1) / `FPSC_CLK_NS)
`define FPSC_SCLK_LOW_CYC \
    ((`FPSC_SCLK_LOW_NS + `FPSC_CLK_NS - 1) / `FPSC_CLK_NS)
`define FPSC_LATCH_CYC ((`FPSC_LATCH_NS + `FPSC_CLK_NS - 1) / `FPSC_CLK_NS)

// ----------------------------------------------------------------------
// Scan chain layout
// ----------------------------------------------------------------------
`define FPSC_POSITIONS 48
`define FPSC_POS_W 6
`define FPSC_TIMER_W 7
`define FPSC_FRAME_W 13
`define FPSC_LANES 2
`define FPSC_KNOBS 4
`define FPSC_KNOB_BITS 8

`endif

// *** core/fpsc_scan_controller.v ***
`timescale 1ns/10ps
`include "fpsc_regs.vh"

module fpsc_scan_controller #(
    parameter FRAME_CYCLES = `FPSC_FRAME_CYC
) (
    mclk,
    rst,
    fourChannelBuild,
    laneAScanData,
    laneBScanData,
    indicatorSlot,
    selfTestStart,
    selfTestExit,
    laneAScanClear,
    laneAScanClock,
    laneBScanClear,
    laneBScanClock,
    indicatorLatchStrobe,
    scanUpdate,
    panelState,
    pressEvents,
    releaseEvents,
    knobCw,
    knobCcw,
    selfTestActive,
    selfTestComplete
);
    localparam NBITS = `FPSC_LANES * `FPSC_POSITIONS;
    localparam NKNOB = `FPSC_LANES * `FPSC_KNOBS;

    input wire mclk;
    input wire rst;
    input wire fourChannelBuild;
    input wire laneAScanData;
    input wire laneBScanData;
    input wire [`FPSC_POS_W-1:0] indicatorSlot;
    input wire selfTestStart;
    input wire selfTestExit;
    output wire laneAScanClear;
    output wire laneAScanClock;
    output wire laneBScanClear;
    output wire laneBScanClock;
    output reg indicatorLatchStrobe;
    output reg scanUpdate;
    output reg [NBITS-1:0] panelState;
    output reg [NBITS-1:0] pressEvents;
    output reg [NBITS-1:0] releaseEvents;
    output reg [NKNOB-1:0] knobCw;
    output reg [NKNOB-1:0] knobCcw;
    output reg selfTestActive;
    output reg selfTestComplete;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Quadrature step from previous and current phase pairs:
    // bit 0 marks clockwise, bit 1 counter-clockwise
    function [1:0] quadDir;
        input [1:0] prevPh;
        input [1:0] curPh;
        begin
            case ({prevPh, curPh})
                4'h1, 4'h7, 4'hE, 4'h8: quadDir = 2'h1;
                4'h2, 4'hB, 4'hD, 4'h4: quadDir = 2'h2;
                default: quadDir = 2'h0;
            endcase
        end
    endfunction

    // Knob k of a lane owns positions 2k and 2k+1; the rest are buttons
    function isButton;
        input integer bitIdx;
        begin
            isButton = (bitIdx % `FPSC_POSITIONS) >= `FPSC_KNOB_BITS;
        end
    endfunction

    // ------------------------------------------------------------------
    // Build strap synchroniser
    // ------------------------------------------------------------------
    reg strapMeta_reg;
    reg strapSync_reg;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            strapMeta_reg <= 1'b0;
            strapSync_reg <= 1'b0;
        end else begin
            strapMeta_reg <= fourChannelBuild;
            strapSync_reg <= strapMeta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Frame timer, shared so both lanes stay aligned to the latch
    // ------------------------------------------------------------------
    localparam integer FRAME_LAST_I = FRAME_CYCLES - 1;
    localparam integer CLEAR_LEN_I = `FPSC_CLEAR_CYC;
    localparam integer SCLK_LEN_I = `FPSC_SCLK_CYC;
    localparam integer LATCH_LAST_I = `FPSC_LATCH_CYC - 1;
    localparam [`FPSC_FRAME_W-1:0] FRAME_LAST =
        FRAME_LAST_I[`FPSC_FRAME_W-1:0];
    localparam [`FPSC_FRAME_W-1:0] CLEAR_LEN = CLEAR_LEN_I[`FPSC_FRAME_W-1:0];
    localparam [`FPSC_TIMER_W-1:0] SCLK_LEN = SCLK_LEN_I[`FPSC_TIMER_W-1:0];
    localparam [3:0] LATCH_LAST = LATCH_LAST_I[3:0];

    reg [`FPSC_FRAME_W-1:0] frameCnt_reg;
    reg [3:0] latchCnt_reg;
    wire frameStart;
    wire [`FPSC_FRAME_W-1:0] latchOffset;

    assign frameStart = (frameCnt_reg == {`FPSC_FRAME_W{1'b0}});
    // Latch lands at the selected clock slot counted from the clear pulse
    assign latchOffset = CLEAR_LEN + indicatorSlot * SCLK_LEN;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            frameCnt_reg <= {`FPSC_FRAME_W{1'b0}};
            latchCnt_reg <= 4'h0;
            indicatorLatchStrobe <= 1'b1;
        end else begin
            if (frameCnt_reg == FRAME_LAST) begin
                frameCnt_reg <= {`FPSC_FRAME_W{1'b0}};
            end else begin
                frameCnt_reg <= frameCnt_reg + 1'b1;
            end
            if (frameCnt_reg == latchOffset) begin
                indicatorLatchStrobe <= 1'b0;
                latchCnt_reg <= LATCH_LAST;
            end else if (latchCnt_reg != 4'h0) begin
                latchCnt_reg <= latchCnt_reg - 1'b1;
            end else begin
                indicatorLatchStrobe <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Scan lanes
    // ------------------------------------------------------------------
    wire [NBITS-1:0] laneWords;
    wire [`FPSC_LANES-1:0] laneValid;

    fpsc_lane u_laneA (
        .mclk(mclk),
        .rst(rst),
        .laneEnable(1'b1),
        .frameStart(frameStart),
        .scanDataPin(laneAScanData),
        .scanClear(laneAScanClear),
        .scanClock(laneAScanClock),
        .scanWord(laneWords[`FPSC_POSITIONS-1:0]),
        .scanValid(laneValid[0])
    );

    // Lane B runs only when the strap says four channels
    fpsc_lane u_laneB (
        .mclk(mclk),
        .rst(rst),
        .laneEnable(strapSync_reg),
        .frameStart(frameStart),
        .scanDataPin(laneBScanData),
        .scanClear(laneBScanClear),
        .scanClock(laneBScanClock),
        .scanWord(laneWords[NBITS-1:`FPSC_POSITIONS]),
        .scanValid(laneValid[1])
    );

    // ------------------------------------------------------------------
    // Change detection against the previous scan
    // ------------------------------------------------------------------
    reg [NBITS-1:0] pressNext;
    reg [NBITS-1:0] releaseNext;
    reg [NKNOB-1:0] cwNext;
    reg [NKNOB-1:0] ccwNext;
    reg [NBITS-1:0] stateNext;
    reg [1:0] dirTmp;
    integer i;
    integer k;
    integer ln;

    always @* begin
        pressNext = {NBITS{1'b0}};
        releaseNext = {NBITS{1'b0}};
        cwNext = {NKNOB{1'b0}};
        ccwNext = {NKNOB{1'b0}};
        stateNext = panelState;
        dirTmp = 2'h0;
        for (i = 0; i < NBITS; i = i + 1) begin
            ln = i / `FPSC_POSITIONS;
            if (laneValid[ln]) begin
                stateNext[i] = laneWords[i];
                if (isButton(i)) begin
                    pressNext[i] = laneWords[i] & ~panelState[i];
                    releaseNext[i] = ~laneWords[i] & panelState[i];
                end
            end
        end
        for (k = 0; k < NKNOB; k = k + 1) begin
            ln = k / `FPSC_KNOBS;
            i = ln * `FPSC_POSITIONS + 2 * (k % `FPSC_KNOBS);
            if (laneValid[ln]) begin
                dirTmp = quadDir(panelState[i+1 -: 2],
                    laneWords[i+1 -: 2]);
                cwNext[k] = dirTmp[0];
                ccwNext[k] = dirTmp[1];
            end
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            panelState <= {NBITS{1'b0}};
            pressEvents <= {NBITS{1'b0}};
            releaseEvents <= {NBITS{1'b0}};
            knobCw <= {NKNOB{1'b0}};
            knobCcw <= {NKNOB{1'b0}};
            scanUpdate <= 1'b0;
        end else begin
            panelState <= stateNext;
            pressEvents <= pressNext;
            releaseEvents <= releaseNext;
            knobCw <= cwNext;
            knobCcw <= ccwNext;
            scanUpdate <= |laneValid;
        end
    end

    // ------------------------------------------------------------------
    // Panel self-test bookkeeping
    // ------------------------------------------------------------------
    reg [NBITS-1:0] seenPress_reg;
    reg [NKNOB-1:0] seenCw_reg;
    reg [NKNOB-1:0] seenCcw_reg;
    reg [NBITS-1:0] needPress;
    reg [NKNOB-1:0] needKnob;
    wire allSeen;
    integer bi;
    integer bk;

    // Lane B controls only count when that half of the panel is fitted
    always @* begin
        needPress = {NBITS{1'b0}};
        needKnob = {NKNOB{1'b0}};
        for (bi = 0; bi < NBITS; bi = bi + 1) begin
            needPress[bi] = isButton(bi) &&
                ((bi < `FPSC_POSITIONS) || strapSync_reg);
        end
        for (bk = 0; bk < NKNOB; bk = bk + 1) begin
            needKnob[bk] = (bk < `FPSC_KNOBS) || strapSync_reg;
        end
    end

    assign allSeen = ((seenPress_reg & needPress) == needPress) &&
        ((seenCw_reg & needKnob) == needKnob) &&
        ((seenCcw_reg & needKnob) == needKnob);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            seenPress_reg <= {NBITS{1'b0}};
            seenCw_reg <= {NKNOB{1'b0}};
            seenCcw_reg <= {NKNOB{1'b0}};
            selfTestActive <= 1'b0;
            selfTestComplete <= 1'b0;
        end else begin
            selfTestComplete <= selfTestActive && allSeen;
            if (selfTestStart) begin
                seenPress_reg <= {NBITS{1'b0}};
                seenCw_reg <= {NKNOB{1'b0}};
                seenCcw_reg <= {NKNOB{1'b0}};
                selfTestActive <= 1'b1;
            end else if (selfTestActive) begin
                seenPress_reg <= seenPress_reg | pressEvents;
                seenCw_reg <= seenCw_reg | knobCw;
                seenCcw_reg <= seenCcw_reg | knobCcw;
                // Exit requests before full coverage are ignored
                if (selfTestExit && allSeen) begin
                    selfTestActive <= 1'b0;
                end
            end
        end
    end

endmodule // fpsc_scan_controller

// *** tb/fpsc_panel_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Panel scan chain: one position per scan clock, restarted by clear
// ----------------------------------------------------------------------
module fpsc_panel_model (
    input logic mclk,
    input logic rst,
    input logic fitted,
    input logic [47:0] patA,
    input logic [47:0] patB,
    input logic clrA,
    input logic clkA,
    input logic clrB,
    input logic clkB,
    output logic dataA,
    output logic dataB
);
    logic [5:0] posA, posB;
    logic prevA, prevB, wiggle;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            posA <= 6'h30;
            posB <= 6'h30;
            prevA <= 1'b0;
            prevB <= 1'b0;
            wiggle <= 1'b0;
        end else begin
            wiggle <= ~wiggle;
            prevA <= clkA;
            prevB <= clkB;
            if (clrA) posA <= 6'h00;
            else if (clkA && !prevA && posA != 6'h30) posA <= posA + 6'h01;
            if (clrB) posB <= 6'h00;
            else if (clkB && !prevB && posB != 6'h30) posB <= posB + 6'h01;
        end
    end
    // Past the chain end, or unfitted, the line floats: never a held bit
    assign dataA = (posA < 6'h30) ? patA[posA] : wiggle;
    assign dataB = (fitted && posB < 6'h30) ? patB[posB] : wiggle;
endmodule // fpsc_panel_model

// *** tb/fpsc_scan_chk.sv ***
`timescale 1ns/10ps
module fpsc_scan_chk #(
    parameter FRAME_CYCLES = 7763
) (
    input logic mclk,
    input logic rst,
    input logic fourChannelBuild,
    input logic [5:0] indicatorSlot,
    input logic selfTestStart,
    input logic selfTestExit,
    input logic laneAScanClear,
    input logic laneAScanClock,
    input logic laneBScanClear,
    input logic laneBScanClock,
    input logic indicatorLatchStrobe,
    input logic scanUpdate,
    input logic [95:0] panelState,
    input logic [95:0] pressEvents,
    input logic [95:0] releaseEvents,
    input logic selfTestActive,
    input logic selfTestComplete
);
    // ------------------------------------------------------------------
    // Cycles since lane A clear rose; age of a low strap
    // ------------------------------------------------------------------
    logic [15:0] sinceClr;
    logic [2:0] strapLo;
    logic clrPrev, armed;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sinceClr <= 16'h0000;
            strapLo <= 3'h0;
            clrPrev <= 1'b0;
            armed <= 1'b0;
        end else begin
            clrPrev <= laneAScanClear;
            if (laneAScanClear && !clrPrev) begin
                sinceClr <= 16'h0000;
                armed <= 1'b1;
            end else if (sinceClr != 16'hFFFF) begin
                sinceClr <= sinceClr + 16'h0001;
            end
            if (fourChannelBuild) strapLo <= 3'h0;
            else if (strapLo != 3'h7) strapLo <= strapLo + 3'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_clear_width: assert property ($rose(laneAScanClear) |->
        laneAScanClear[*3] ##1 !laneAScanClear) else $error("clear width");
    a_clear_period: assert property ($rose(laneAScanClear)
        && armed |-> sinceClr == FRAME_CYCLES - 1) else $error("clear period");
    a_sclk_low: assert property ($fell(laneAScanClock) |->
        !laneAScanClock[*3] ##1 laneAScanClock) else $error("clock low");
    a_sclk_slot: assert property ($fell(laneAScanClock) |->
        sinceClr >= 122 && sinceClr <= 5903 && (sinceClr - 122) % 123 == 0)
        else $error("slot");
    a_sclk_first: assert property ($fell(laneAScanClear) |->
        ##120 $fell(laneAScanClock)) else $error("first clock");
    a_latch_low: assert property ($fell(indicatorLatchStrobe) |->
        !indicatorLatchStrobe[*6] ##1 indicatorLatchStrobe) else $error("latch");
    a_latch_place: assert property ($fell(indicatorLatchStrobe)
        |-> sinceClr == 2 + 123 * indicatorSlot) else $error("latch place");
    a_laneb_idle: assert property (strapLo == 3'h7 |->
        !laneBScanClear && !laneBScanClock) else $error("lane B active");
    a_update_pulse: assert property (scanUpdate |=> !scanUpdate)
        else $error("update width");
    a_event_state: assert property (scanUpdate |->
        (pressEvents & ~panelState) == 96'h0
        && (releaseEvents & panelState) == 96'h0) else $error("event state");
    a_exit_gate: assert property ($fell(selfTestActive) |->
        selfTestComplete && $past(selfTestExit)) else $error("exit");
    a_start_arm: assert property (selfTestStart |=>
        selfTestActive ##1 !selfTestComplete) else $error("start");
endmodule // fpsc_scan_chk

bind fpsc_scan_controller fpsc_scan_chk #(.FRAME_CYCLES(FRAME_CYCLES)) i_chk (
    .mclk(mclk), .rst(rst), .fourChannelBuild(fourChannelBuild),
    .indicatorSlot(indicatorSlot), .selfTestStart(selfTestStart),
    .selfTestExit(selfTestExit), .laneAScanClear(laneAScanClear),
    .laneAScanClock(laneAScanClock), .laneBScanClear(laneBScanClear),
    .laneBScanClock(laneBScanClock), .scanUpdate(scanUpdate),
    .indicatorLatchStrobe(indicatorLatchStrobe), .panelState(panelState),
    .pressEvents(pressEvents), .releaseEvents(releaseEvents),
    .selfTestActive(selfTestActive), .selfTestComplete(selfTestComplete));

// *** tb/tb.sv ***
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("ERROR %0t: got %h exp %h", $time, got, exp); \
    end \
end
module tb;
    typedef struct packed {
        logic strap;
        logic [5:0] slot;
        logic [47:0] a;
        logic [47:0] b;
        logic [1:0] dir;
        logic done;
        logic act;
    } fpsc_row_t;
    localparam logic [95:0] BTN = {2{48'hFFFFFFFFFF00}};
    logic mclk, rst, fourChannelBuild, selfTestStart, selfTestExit;
    logic [5:0] indicatorSlot;
    logic [47:0] patA, patB;
    logic [95:0] pressAcc, relAcc, cur, prev;
    logic [7:0] cwAcc, ccwAcc, expCw;
    wire laneAScanData, laneBScanData, laneAScanClear, laneAScanClock;
    wire laneBScanClear, laneBScanClock, indicatorLatchStrobe, scanUpdate;
    wire selfTestActive, selfTestComplete;
    wire [95:0] panelState, pressEvents, releaseEvents;
    wire [7:0] knobCw, knobCcw;
    int err_total, samples_checked, cycles, r;
    fpsc_row_t rows [0:6];
    fpsc_row_t w;

    fpsc_scan_controller #(.FRAME_CYCLES(6000)) i_dut (
        .mclk(mclk), .rst(rst), .fourChannelBuild(fourChannelBuild),
        .laneAScanData(laneAScanData), .laneBScanData(laneBScanData),
        .indicatorSlot(indicatorSlot), .selfTestStart(selfTestStart),
        .selfTestExit(selfTestExit), .laneAScanClear(laneAScanClear),
        .laneAScanClock(laneAScanClock), .laneBScanClear(laneBScanClear),
        .laneBScanClock(laneBScanClock), .scanUpdate(scanUpdate),
        .indicatorLatchStrobe(indicatorLatchStrobe), .panelState(panelState),
        .pressEvents(pressEvents), .releaseEvents(releaseEvents),
        .knobCw(knobCw), .knobCcw(knobCcw), .selfTestActive(selfTestActive),
        .selfTestComplete(selfTestComplete));

    fpsc_panel_model i_panel (
        .mclk(mclk), .rst(rst), .fitted(fourChannelBuild), .patA(patA),
        .patB(patB), .clrA(laneAScanClear), .clkA(laneAScanClock),
        .clrB(laneBScanClear), .clkB(laneBScanClock),
        .dataA(laneAScanData), .dataB(laneBScanData));

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Waits for a frame to start, then for its scan result to land
    task automatic waitScan;
        int n;
        n = 0;
        while (laneAScanClear !== 1'b1 && n < 7000) begin
            @(negedge mclk);
            n++;
        end
        while (scanUpdate !== 1'b1 && n < 14000) begin
            @(negedge mclk);
            n++;
        end
        `CHK(n < 14000, 1'b1)
        repeat (8) @(negedge mclk);
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Events of one frame gather here; each clear pulse starts afresh
    always @(negedge mclk) begin
        if (laneAScanClear === 1'b1) begin
            pressAcc <= 96'h0;
            relAcc <= 96'h0;
            cwAcc <= 8'h00;
            ccwAcc <= 8'h00;
        end else if (scanUpdate === 1'b1) begin
            pressAcc <= pressAcc | pressEvents;
            relAcc <= relAcc | releaseEvents;
            cwAcc <= cwAcc | knobCw;
            ccwAcc <= ccwAcc | knobCcw;
        end
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        // Knob phases step 00-01-11-10-11-00 on lane A; last is a double step
        rows[0] = '{1'h0, 6'h00, 48'h0, 48'h0, 2'h0, 1'h0, 1'h1};
        rows[1] = '{1'h0, 6'h2F, 48'hFFFFFFFFFF55, 48'h0, 2'h1, 1'h0, 1'h1};
        rows[2] = '{1'h0, 6'h14, 48'h0000000000FF, 48'h0, 2'h1, 1'h0, 1'h1};
        rows[3] = '{1'h0, 6'h00, 48'h0000000000AA, 48'h0, 2'h1, 1'h0, 1'h1};
        rows[4] = '{1'h0, 6'h2F, 48'h0000000000FF, 48'h0, 2'h2, 1'h1, 1'h0};
        rows[5] = '{1'h1, 6'h14, 48'h0, 48'hA5A5A5A50000, 2'h0, 1'h0, 1'h0};
        rows[6] = '{1'h1, 6'h00, 48'h0, 48'h0, 2'h0, 1'h0, 1'h0};
        err_total = 0;
        samples_checked = 0;
        cycles = 0;
        rst = 1'b1;
        fourChannelBuild = 1'b0;
        selfTestStart = 1'b0;
        selfTestExit = 1'b0;
        indicatorSlot = 6'h00;
        patA = 48'h0;
        patB = 48'h0;
        prev = 96'h0;
        repeat (8) @(negedge mclk);
        `CHK({laneAScanClear, laneBScanClear, laneBScanClock}, 3'h0)
        `CHK({indicatorLatchStrobe, scanUpdate, selfTestActive}, 3'h4)
        rst = 1'b0;
        selfTestStart = 1'b1;
        @(negedge mclk);
        selfTestStart = 1'b0;
        for (r = 0; r < 7; r++) begin
            w = rows[r];
            fourChannelBuild = w.strap;
            indicatorSlot = w.slot;
            patA = w.a;
            patB = w.b;
            waitScan();
            cur = {w.strap ? w.b : 48'h0, w.a};
            // dir 1: lane A knobs step clockwise, dir 2: counter-clockwise
            expCw = (w.dir == 2'h1) ? 8'h0F : 8'h00;
            `CHK(panelState, cur)
            `CHK(pressAcc, cur & ~prev & BTN)
            `CHK(relAcc, prev & ~cur & BTN)
            `CHK(cwAcc, expCw)
            `CHK(ccwAcc, (w.dir == 2'h2) ? 8'h0F : 8'h00)
            `CHK(selfTestComplete, w.done)
            selfTestExit = 1'b1;
            @(negedge mclk);
            selfTestExit = 1'b0;
            @(negedge mclk);
            `CHK(selfTestActive, w.act)
            prev = cur;
            $display("row %0d done", r);
        end
        // A restart forgets what was seen, so the test cannot exit at once
        selfTestStart = 1'b1;
        @(negedge mclk);
        selfTestStart = 1'b0;
        `CHK(selfTestActive, 1'b1)
        @(negedge mclk);
        `CHK(selfTestComplete, 1'b0)
        $display("restart test done");
        repeat (300) @(negedge mclk);
        rst = 1'b1;
        fourChannelBuild = 1'b0;
        patA = 48'h800000000100;
        @(negedge mclk);
        `CHK({laneAScanClear, laneBScanClear, laneBScanClock}, 3'h0)
        rst = 1'b0;
        waitScan();
        `CHK(panelState, {48'h0, patA})
        `CHK(pressAcc, {48'h0, patA})
        $display("mid-run reset test done");
        end_sim();
    end
endmodule // tb
